// ==== logic/prio_classifier.sv ====
// Ingress priority classifier: port, tag and code point sources.
// Assumes a request is a one-cycle strobe; the result follows one cycle on.
`timescale 1ns/100ps
module prio_classifier (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Carrier
    qos_stp_if.cls    bus
);
    typedef struct packed {
        logic       valid;
        logic [1:0] level;
        logic [1:0] queue;
    } cls_state_t;

    cls_state_t q;
    cls_state_t d;

    function automatic logic [1:0] max2(input logic [1:0] a,
                                        input logic [1:0] b);
        max2 = (a > b) ? a : b;
    endfunction

    logic [7:0]  c0;
    logic [7:0]  c2;
    logic [2:0]  dflt_pri;
    logic [2:0]  upri;
    logic [1:0]  lvl;

    always_comb begin
        c0       = bus.ctrl0[bus.req_port];
        c2       = bus.ctrl2[bus.req_port];
        dflt_pri = bus.def_tag[bus.req_port][switch_port_pkg::TAG_PRI_LO +: 3];
        upri     = bus.req_upri;
        // Ceiling clamps the tag priority before it is mapped
        if (c2[switch_port_pkg::CTRL2_CEIL_BIT] && (upri > dflt_pri)) begin
            upri = dflt_pri;
        end
        lvl = c0[switch_port_pkg::CTRL0_PORT_PRI_LO +: 2];
        // Disagreeing sources resolve to the highest level
        if (c0[switch_port_pkg::CTRL0_TAG_PRI_BIT]
            && bus.req_tagged) begin
            lvl = max2(lvl, bus.pri_map[{upri, 1'b0} +: 2]);
        end
        if (bus.dscp_en[bus.req_port] && bus.req_ip) begin
            lvl = max2(lvl, bus.dscp_map[{bus.req_dscp, 1'b0} +: 2]);
        end
        d       = q;
        d.valid = bus.req_valid;
        if (bus.req_valid) begin
            d.level = lvl;
            case (bus.req_split)
                switch_port_pkg::Q_FOUR: d.queue = lvl;
                switch_port_pkg::Q_TWO:  d.queue = {1'b0, lvl == 2'h3};
                default:                 d.queue = 2'h0;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.res_valid = q.valid;
    assign bus.res_level = q.level;
    assign bus.res_queue = q.queue;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    chk_high_queue: assert property (
        (bus.req_valid && bus.req_split == switch_port_pkg::Q_TWO)
        |=> (bus.res_queue == {1'b0, bus.res_level == 2'h3}))
        else $error("two-queue mapping wrong");
    chk_single_queue: assert property (
        (bus.req_valid && bus.req_split == switch_port_pkg::Q_SINGLE)
        |=> (bus.res_valid && bus.res_queue == 2'h0))
        else $error("single queue not zero");
    chk_port_floor: assert property (
        bus.req_valid |=> (bus.res_level >=
            $past(bus.ctrl0[bus.req_port][4:3])))
        else $error("level below port priority");
endmodule

// ==== logic/stp_gate.sv ====
// Spanning tree gate for the network ports; the host port is never gated.
// Assumes queries are steady for a cycle; verdicts are registered.
`timescale 1ns/100ps
module stp_gate (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Carrier
    qos_stp_if.gate   bus
);
    typedef struct packed {
        logic rx_accept;
        logic rx_learn;
        logic tx_allow;
    } gate_state_t;

    gate_state_t q;
    gate_state_t d;
    logic [7:0]  rc;
    logic [7:0]  tc;

    always_comb begin
        rc = bus.ctrl2[bus.rx_port];
        tc = bus.ctrl2[bus.tx_port];
        d  = '0;
        if (bus.rx_port == switch_port_pkg::HOST_PORT) begin
            d.rx_accept = 1'b1;
            d.rx_learn  = 1'b1;
        end else if (rc[switch_port_pkg::CTRL2_RX_EN]) begin
            d.rx_accept = 1'b1;
            d.rx_learn  = !rc[switch_port_pkg::CTRL2_LEARN_DIS];
        end else if (!rc[switch_port_pkg::CTRL2_LEARN_DIS]) begin
            d.rx_accept = bus.rx_to_host;
            d.rx_learn  = 1'b1;
        end else begin
            // Disabled, blocking and listening share one setting
            d.rx_accept = bus.rx_to_host && bus.rx_override;
            d.rx_learn  = 1'b0;
        end
        if (bus.tx_port == switch_port_pkg::HOST_PORT) begin
            d.tx_allow = 1'b1;
        end else if (tc[switch_port_pkg::CTRL2_TX_EN]) begin
            d.tx_allow = 1'b1;
        end else begin
            // Only host frames may go out to disabled and blocking ports
            d.tx_allow = bus.tx_from_host;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.rx_accept = q.rx_accept;
    assign bus.rx_learn  = q.rx_learn;
    assign bus.tx_allow  = q.tx_allow;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    chk_no_learn_disabled: assert property (
        (bus.rx_port != 2'h3 && bus.ctrl2[bus.rx_port][0]
         && !bus.ctrl2[bus.rx_port][1]) |=> !bus.rx_learn)
        else $error("learning while disabled");
    chk_user_blocked: assert property (
        (bus.rx_port != 2'h3 && bus.ctrl2[bus.rx_port][0]
         && !bus.ctrl2[bus.rx_port][1] && !bus.rx_override)
        |=> !bus.rx_accept)
        else $error("blocked port accepted traffic");
    chk_forward_all: assert property (
        (bus.ctrl2[bus.rx_port][1] && !bus.ctrl2[bus.rx_port][0])
        |=> (bus.rx_accept && bus.rx_learn))
        else $error("forwarding port refused traffic");
endmodule

// ==== logic/switch_port_top.sv ====
// Per-port packet handling: ingress classification, spanning tree gating
// and egress tag insertion or removal with frame check recompute.
// Assumes byte streams carry the full frame including its check sequence.
`timescale 1ns/100ps
module switch_port_top (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    // Per-port configuration and shared priority maps
    input  wire logic [3:0][7:0]  ctrl0_i,
    input  wire logic [3:0][7:0]  ctrl2_i,
    input  wire logic [3:0][15:0] def_tag_i,
    input  wire logic [15:0]      pri_map_i,
    input  wire logic [127:0]     dscp_map_i,
    input  wire logic [3:0]       dscp_en_i,
    // Ingress classification request
    input  wire logic             cls_valid_i,
    input  wire logic [1:0]       cls_port_i,
    input  wire logic             cls_tagged_i,
    input  wire logic [2:0]       cls_upri_i,
    input  wire logic             cls_ip_i,
    input  wire logic [5:0]       cls_dscp_i,
    input  wire logic [1:0]       cls_split_i,
    // Classification result
    output logic                  cls_valid_o,
    output logic [1:0]            cls_level_o,
    output logic [1:0]            cls_queue_o,
    // Spanning tree query
    input  wire logic [1:0]       stp_rx_port_i,
    input  wire logic             stp_rx_to_host_i,
    input  wire logic             stp_rx_override_i,
    input  wire logic [1:0]       stp_tx_port_i,
    input  wire logic             stp_tx_from_host_i,
    // Spanning tree verdict
    output logic                  stp_rx_accept_o,
    output logic                  stp_rx_learn_o,
    output logic                  stp_tx_allow_o,
    // Egress port setup
    input  wire logic [1:0]       eg_port_i,
    input  wire logic [3:0]       eg_ins_mask_i,
    // Egress frame in
    input  wire logic             eg_in_valid_i,
    output logic                  eg_in_ready_o,
    input  wire logic [7:0]       eg_in_data_i,
    input  wire logic             eg_in_last_i,
    input  wire logic [1:0]       eg_in_src_i,
    input  wire logic             eg_in_tagged_i,
    // Egress frame out
    output logic                  eg_out_valid_o,
    input  wire logic             eg_out_ready_i,
    output logic [7:0]            eg_out_data_o,
    output logic                  eg_out_last_o
);
    qos_stp_if bus ();

    assign bus.ctrl0        = ctrl0_i;
    assign bus.ctrl2        = ctrl2_i;
    assign bus.def_tag      = def_tag_i;
    assign bus.pri_map      = pri_map_i;
    assign bus.dscp_map     = dscp_map_i;
    assign bus.dscp_en      = dscp_en_i;
    assign bus.req_valid    = cls_valid_i;
    assign bus.req_port     = cls_port_i;
    assign bus.req_tagged   = cls_tagged_i;
    assign bus.req_upri     = cls_upri_i;
    assign bus.req_ip       = cls_ip_i;
    assign bus.req_dscp     = cls_dscp_i;
    assign bus.req_split    = cls_split_i;
    assign bus.rx_port      = stp_rx_port_i;
    assign bus.rx_to_host   = stp_rx_to_host_i;
    assign bus.rx_override  = stp_rx_override_i;
    assign bus.tx_port      = stp_tx_port_i;
    assign bus.tx_from_host = stp_tx_from_host_i;

    assign cls_valid_o     = bus.res_valid;
    assign cls_level_o     = bus.res_level;
    assign cls_queue_o     = bus.res_queue;
    assign stp_rx_accept_o = bus.rx_accept;
    assign stp_rx_learn_o  = bus.rx_learn;
    assign stp_tx_allow_o  = bus.tx_allow;

    prio_classifier u_cls (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .bus     (bus.cls)
    );

    stp_gate u_stp (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .bus     (bus.gate)
    );

    // Egress tag editor
    typedef struct packed {
        switch_port_pkg::edit_state_t st;
        logic [11:0]                  cnt;
        logic [1:0]                   k;
        logic [3:0][7:0]              dly;
        logic [31:0]                  crc;
        logic                         ins;
        logic                         rem;
        logic [15:0]                  tag;
        logic                         ov;
        logic [7:0]                   od;
        logic                         ol;
    } edit_t;

    edit_t q;
    edit_t d;

    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0]  b);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ b[i]) begin
                r = (r >> 1) ^ switch_port_pkg::CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        crc_byte = r;
    endfunction

    logic        can_load;
    logic        take;
    logic [11:0] pos;
    logic [7:0]  old;
    logic [7:0]  c0e;
    logic [31:0] fcs;
    logic        drop;

    // Output register frees when it is empty or being taken downstream
    assign can_load = !q.ov || eg_out_ready_i;
    assign eg_in_ready_o = (q.st == switch_port_pkg::S_RUN) && can_load;
    assign take = eg_in_valid_i && eg_in_ready_o;
    assign pos  = q.cnt - switch_port_pkg::FCS_LEN;
    assign old  = q.dly[3];
    assign c0e  = ctrl0_i[eg_port_i];
    assign fcs  = ~q.crc;
    assign drop = q.rem && (pos >= switch_port_pkg::TAG_POS)
                  && (pos < switch_port_pkg::TAG_POS
                            + switch_port_pkg::TAG_LEN);

    always_comb begin
        d = q;
        if (eg_out_ready_i) begin
            d.ov = 1'b0;
        end
        case (q.st)
            switch_port_pkg::S_RUN: begin
                if (take) begin
                    d.dly = {q.dly[2:0], eg_in_data_i};
                    if (q.cnt != switch_port_pkg::CNT_MAX) begin
                        d.cnt = q.cnt + 12'h001;
                    end
                    if (q.cnt == 12'h000) begin
                        d.crc = switch_port_pkg::CRC_INIT;
                        d.ins = c0e[switch_port_pkg::CTRL0_INS_BIT]
                                && !eg_in_tagged_i
                                && eg_ins_mask_i[eg_in_src_i];
                        d.rem = c0e[switch_port_pkg::CTRL0_REM_BIT]
                                && eg_in_tagged_i;
                        d.tag = def_tag_i[eg_in_src_i];
                    end
                    // The four newest bytes are held back as a possible FCS
                    if (q.cnt >= switch_port_pkg::FCS_LEN && !drop) begin
                        d.ov  = 1'b1;
                        d.od  = old;
                        d.ol  = 1'b0;
                        d.crc = crc_byte(q.crc, old);
                    end
                    if (eg_in_last_i) begin
                        d.st = switch_port_pkg::S_FCS;
                        d.k  = 2'h0;
                    end else if (q.ins && q.cnt >= switch_port_pkg::FCS_LEN
                                 && pos == switch_port_pkg::TAG_POS
                                           - 12'h001) begin
                        d.st = switch_port_pkg::S_INS;
                        d.k  = 2'h0;
                    end
                end
            end
            switch_port_pkg::S_INS: begin
                if (can_load) begin
                    d.ov = 1'b1;
                    d.ol = 1'b0;
                    case (q.k)
                        2'h0:    d.od = switch_port_pkg::TPID[15:8];
                        2'h1:    d.od = switch_port_pkg::TPID[7:0];
                        2'h2:    d.od = q.tag[15:8];
                        default: d.od = q.tag[7:0];
                    endcase
                    d.crc = crc_byte(q.crc, d.od);
                    d.k   = q.k + 2'h1;
                    if (q.k == 2'h3) begin
                        d.st = switch_port_pkg::S_RUN;
                    end
                end
            end
            switch_port_pkg::S_FCS: begin
                if (can_load) begin
                    d.ov = 1'b1;
                    d.ol = (q.k == 2'h3);
                    // Untouched frames keep their own FCS so errors survive
                    if (q.ins || q.rem) begin
                        d.od = fcs[{q.k, 3'h0} +: 8];
                    end else begin
                        d.od = q.dly[2'h3 - q.k];
                    end
                    d.k = q.k + 2'h1;
                    if (q.k == 2'h3) begin
                        d.st  = switch_port_pkg::S_RUN;
                        d.cnt = 12'h000;
                        d.ins = 1'b0;
                        d.rem = 1'b0;
                    end
                end
            end
            default: begin
                d.st = switch_port_pkg::S_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign eg_out_valid_o = q.ov;
    assign eg_out_data_o  = q.od;
    assign eg_out_last_o  = q.ol;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    chk_no_double_tag: assert property (
        (take && q.cnt == 12'h000 && eg_in_tagged_i) |=> !q.ins)
        else $error("insertion armed on tagged frame");
    chk_tpid_first: assert property (
        (q.st == switch_port_pkg::S_INS && q.k == 2'h0 && can_load)
        |=> (eg_out_valid_o && eg_out_data_o == 8'h81))
        else $error("inserted tag does not start with TPID");
    chk_tag_dropped: assert property (
        (take && drop && q.cnt >= 12'h004) |=> !eg_out_valid_o)
        else $error("tag byte not removed");
    chk_fcs_byte: assert property (
        (q.st == switch_port_pkg::S_FCS && q.k == 2'h3 && can_load
         && (q.ins || q.rem))
        |=> (eg_out_last_o && eg_out_data_o == ~$past(q.crc[31:24])))
        else $error("recomputed FCS byte wrong");
endmodule

// ==== shared/qos_stp_if.sv ====
// Carrier between the port top, the classifier and the spanning tree gate.
// Assumes all signals are synchronous to the switch clock.
`timescale 1ns/100ps
interface qos_stp_if;
    // Configuration
    logic [3:0][7:0]  ctrl0;
    logic [3:0][7:0]  ctrl2;
    logic [3:0][15:0] def_tag;
    logic [15:0]      pri_map;
    logic [127:0]     dscp_map;
    logic [3:0]       dscp_en;
    // Classification request and result
    logic             req_valid;
    logic [1:0]       req_port;
    logic             req_tagged;
    logic [2:0]       req_upri;
    logic             req_ip;
    logic [5:0]       req_dscp;
    logic [1:0]       req_split;
    logic             res_valid;
    logic [1:0]       res_level;
    logic [1:0]       res_queue;
    // Spanning tree query and verdict
    logic [1:0]       rx_port;
    logic             rx_to_host;
    logic             rx_override;
    logic [1:0]       tx_port;
    logic             tx_from_host;
    logic             rx_accept;
    logic             rx_learn;
    logic             tx_allow;

    modport top (
        output ctrl0, ctrl2, def_tag, pri_map, dscp_map, dscp_en,
        output req_valid, req_port, req_tagged, req_upri, req_ip,
        output req_dscp, req_split,
        output rx_port, rx_to_host, rx_override, tx_port, tx_from_host,
        input  res_valid, res_level, res_queue,
        input  rx_accept, rx_learn, tx_allow
    );
    modport cls (
        input  ctrl0, ctrl2, def_tag, pri_map, dscp_map, dscp_en,
        input  req_valid, req_port, req_tagged, req_upri, req_ip,
        input  req_dscp, req_split,
        output res_valid, res_level, res_queue
    );
    modport gate (
        input  ctrl2, rx_port, rx_to_host, rx_override, tx_port,
        input  tx_from_host,
        output rx_accept, rx_learn, tx_allow
    );
endinterface

// ==== shared/switch_port_pkg.sv ====
// Constants, field positions and types shared by the switch port logic.
// Assumes one switch clock; all configuration arrives as plain bit fields.
package switch_port_pkg;
    // First port control field positions
    localparam int unsigned CTRL0_REM_BIT     = 1;
    localparam int unsigned CTRL0_INS_BIT     = 2;
    localparam int unsigned CTRL0_PORT_PRI_LO = 3;
    localparam int unsigned CTRL0_TAG_PRI_BIT = 5;
    // Third port control field positions
    localparam int unsigned CTRL2_LEARN_DIS   = 0;
    localparam int unsigned CTRL2_RX_EN       = 1;
    localparam int unsigned CTRL2_TX_EN       = 2;
    localparam int unsigned CTRL2_CEIL_BIT    = 7;
    // Default tag user priority field
    localparam int unsigned TAG_PRI_LO        = 13;
    // Port numbering (index 3 is the fourth, host port)
    localparam logic [1:0]  HOST_PORT         = 2'h3;
    localparam int unsigned NUM_PORTS         = 4;
    // Frame layout
    localparam logic [15:0] TPID              = 16'h8100;
    localparam logic [11:0] TAG_POS           = 12'h00C;
    localparam logic [11:0] TAG_LEN           = 12'h004;
    localparam logic [11:0] FCS_LEN           = 12'h004;
    localparam logic [11:0] CNT_MAX           = 12'hFFF;
    // Reflected CRC-32 of the frame check sequence
    localparam logic [31:0] CRC_INIT          = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY          = 32'hEDB88320;

    typedef enum logic [1:0] {
        Q_SINGLE,
        Q_TWO,
        Q_FOUR
    } qsplit_t;

    typedef enum logic [1:0] {
        S_RUN,
        S_INS,
        S_FCS
    } edit_state_t;
endpackage

// ==== testbench/eg_sink.sv ====
// Link-side sink for the egress stream; records every byte it takes.
// Assumes the bench raises stall_i to make it hold off every other cycle.
`timescale 1ns/100ps
module eg_sink (
    // Clock and control
    input  wire logic       clock_i,
    input  wire logic       stall_i,
    // Egress stream
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    input  wire logic       last_i,
    output logic            ready_o
);
    logic [7:0] got [0:127];
    int         cnt    = 0;
    int         frames = 0;
    initial ready_o = 1'b1;
    always @(posedge clock_i) begin
        if (valid_i && ready_o) begin
            got[cnt] <= data_i;
            cnt      <= cnt + 1;
            frames   <= frames + int'(last_i);
        end
        // Toggling ready while stalled keeps bytes standing across cycles
        ready_o <= stall_i ? ~ready_o : 1'b1;
    end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench: classifier, spanning tree gate and egress edits.
// Assumes the sink model stands on the egress link side.
`timescale 1ns/100ps
module testbench;
    logic              clock_i = 0, rst_i = 1, stall = 0;
    logic [3:0][7:0]   ctrl0_i = '0, ctrl2_i = '0;
    logic [3:0][15:0]  def_tag_i = '0;
    logic [15:0]       pri_map_i = 16'hFA50;
    logic [127:0]      dscp_map_i = '0;
    logic [3:0]        dscp_en_i = '0, eg_ins_mask_i = 4'hF;
    logic              cls_valid_i = 0, cls_tagged_i = 0, cls_ip_i = 0;
    logic [1:0]        cls_port_i = 0, cls_split_i = 0, eg_port_i = 0;
    logic [2:0]        cls_upri_i = 0;
    logic [5:0]        cls_dscp_i = 0;
    logic              cls_valid_o, stp_rx_accept_o, stp_rx_learn_o;
    logic [1:0]        cls_level_o, cls_queue_o, stp_rx_port_i = 0;
    logic [1:0]        stp_tx_port_i = 0, eg_in_src_i = 0;
    logic              stp_rx_to_host_i = 0, stp_rx_override_i = 0;
    logic              stp_tx_from_host_i = 0, stp_tx_allow_o;
    logic              eg_in_valid_i = 0, eg_in_last_i = 0, eg_in_tagged_i = 0;
    logic              eg_in_ready_o, eg_out_valid_o, eg_out_ready_i;
    logic              eg_out_last_o;
    logic [7:0]        eg_in_data_i = 0, eg_out_data_o;
    int                error_cnt = 0, total_checks = 0;
    always #5 clock_i = ~clock_i;
    switch_port_top DUT (.clock_i(clock_i), .rst_i(rst_i), .ctrl0_i(ctrl0_i),
        .ctrl2_i(ctrl2_i), .def_tag_i(def_tag_i), .pri_map_i(pri_map_i),
        .dscp_map_i(dscp_map_i), .dscp_en_i(dscp_en_i),
        .cls_valid_i(cls_valid_i), .cls_port_i(cls_port_i),
        .cls_tagged_i(cls_tagged_i), .cls_upri_i(cls_upri_i),
        .cls_ip_i(cls_ip_i), .cls_dscp_i(cls_dscp_i),
        .cls_split_i(cls_split_i),
        .cls_valid_o(cls_valid_o), .cls_level_o(cls_level_o),
        .cls_queue_o(cls_queue_o), .stp_rx_port_i(stp_rx_port_i),
        .stp_rx_to_host_i(stp_rx_to_host_i),
        .stp_rx_override_i(stp_rx_override_i), .stp_tx_port_i(stp_tx_port_i),
        .stp_tx_from_host_i(stp_tx_from_host_i),
        .stp_rx_accept_o(stp_rx_accept_o), .stp_rx_learn_o(stp_rx_learn_o),
        .stp_tx_allow_o(stp_tx_allow_o), .eg_port_i(eg_port_i),
        .eg_ins_mask_i(eg_ins_mask_i), .eg_in_valid_i(eg_in_valid_i),
        .eg_in_ready_o(eg_in_ready_o), .eg_in_data_i(eg_in_data_i),
        .eg_in_last_i(eg_in_last_i), .eg_in_src_i(eg_in_src_i),
        .eg_in_tagged_i(eg_in_tagged_i), .eg_out_valid_o(eg_out_valid_o),
        .eg_out_ready_i(eg_out_ready_i), .eg_out_data_o(eg_out_data_o),
        .eg_out_last_o(eg_out_last_o));
    eg_sink sink (.clock_i(clock_i), .stall_i(stall), .valid_i(eg_out_valid_o),
        .data_i(eg_out_data_o), .last_i(eg_out_last_o),
        .ready_o(eg_out_ready_i));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cls(logic [14:0] r, logic [1:0] lv, logic [1:0] q);
        {cls_port_i, cls_tagged_i, cls_upri_i, cls_ip_i, cls_dscp_i,
         cls_split_i} = r;
        cls_valid_i = 1;
        @(posedge clock_i);
        #1 cls_valid_i = 0;
        @(negedge clock_i);
        chk("cls_valid", 1, cls_valid_o);
        chk("cls_level", lv, cls_level_o);
        chk("cls_queue", q, cls_queue_o);
        @(posedge clock_i);
        #1;
    endtask
    task automatic stp(logic [1:0] p, logic [2:0] q, logic [2:0] e);
        {stp_rx_to_host_i, stp_rx_override_i, stp_tx_from_host_i} = q;
        stp_rx_port_i = p;
        stp_tx_port_i = p;
        @(posedge clock_i);
        @(negedge clock_i);
        chk("stp_verdict", e,
            {stp_rx_accept_o, stp_rx_learn_o, stp_tx_allow_o});
        @(posedge clock_i);
        #1;
    endtask
    // Sends a 16-byte body plus 4 check bytes, returns where output started
    task automatic send(logic tg, output int b);
        int f;
        b = sink.cnt;
        f = sink.frames;
        eg_in_src_i = 1;
        eg_in_tagged_i = tg;
        for (int i = 0; i < 20; i++) begin
            eg_in_valid_i = 1;
            eg_in_data_i = 8'(i);
            eg_in_last_i = (i == 19);
            @(negedge clock_i);
            while (eg_in_ready_o !== 1'b1) @(negedge clock_i);
            @(posedge clock_i);
            #1;
        end
        eg_in_valid_i = 0;
        for (int i = 0; i < 200 && sink.frames == f; i++) @(posedge clock_i);
        #1;
    endtask
    function automatic logic [31:0] crc(int b, int n);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = b; i < b + n; i++) begin
            c ^= {24'h0, sink.got[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ switch_port_pkg::CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction
    function automatic logic [31:0] at(int i);
        return {sink.got[i+3], sink.got[i+2], sink.got[i+1], sink.got[i]};
    endfunction
    task automatic t_port;
        logic [12:0] h;
        h = {2'h2, 1'b0, 3'h7, 1'b0, 6'h3F};
        for (int l = 0; l < 4; l++) begin
            ctrl0_i[2][4:3] = 2'(l);
            cls({h, 2'h0}, 2'(l), 2'h0);
            cls({h, 2'h1}, 2'(l), 2'(l == 3));
            cls({h, 2'h2}, 2'(l), 2'(l));
            cls({h, 2'h3}, 2'(l), 2'h0);
        end
    endtask
    task automatic t_tag;
        ctrl0_i[1] = 8'h28;
        def_tag_i[1] = 16'h6ABC;
        cls({2'h1, 1'b1, 3'h7, 1'b0, 6'h0, 2'h2}, 2'h3, 2'h3);
        cls({2'h1, 1'b1, 3'h0, 1'b0, 6'h0, 2'h2}, 2'h1, 2'h1);
        cls({2'h1, 1'b0, 3'h7, 1'b0, 6'h0, 2'h2}, 2'h1, 2'h1);
        ctrl2_i[1][7] = 1;
        cls({2'h1, 1'b1, 3'h7, 1'b0, 6'h0, 2'h2}, 2'h1, 2'h1);
        dscp_en_i[2] = 1;
        dscp_map_i[127:126] = 2'h3;
        dscp_map_i[3:2] = 2'h2;
        ctrl0_i[2] = 8'h00;
        cls({2'h2, 1'b0, 3'h0, 1'b1, 6'h3F, 2'h2}, 2'h3, 2'h3);
        cls({2'h2, 1'b0, 3'h0, 1'b1, 6'h01, 2'h2}, 2'h2, 2'h2);
        cls({2'h2, 1'b0, 3'h0, 1'b0, 6'h3F, 2'h2}, 2'h0, 2'h0);
    endtask
    task automatic t_stp;
        ctrl2_i[0][2:0] = 3'b110;
        stp(2'h0, 3'b000, 3'b111);
        ctrl2_i[0][2:0] = 3'b001;
        stp(2'h0, 3'b100, 3'b000);
        stp(2'h0, 3'b110, 3'b100);
        stp(2'h0, 3'b111, 3'b101);
        ctrl2_i[0][2:0] = 3'b000;
        stp(2'h0, 3'b100, 3'b110);
        stp(2'h0, 3'b001, 3'b011);
        ctrl2_i[3][2:0] = 3'b001;
        stp(2'h3, 3'b000, 3'b111);
    endtask
    task automatic t_egress;
        int b;
        ctrl0_i[0] = 8'h04;
        stall = 1;
        send(0, b);
        chk("ins_len", b + 24, sink.cnt);
        chk("ins_tag", 32'hBC6A0081, at(b + 12));
        chk("ins_body", 12, sink.got[b+16]);
        chk("ins_fcs", crc(b, 20), at(b + 20));
        send(1, b);
        chk("tagged_len", b + 20, sink.cnt);
        chk("tagged_fcs", 32'h13121110, at(b + 16));
        eg_ins_mask_i = 4'hD;
        send(0, b);
        chk("masked_len", b + 20, sink.cnt);
        chk("masked_fcs", 32'h13121110, at(b + 16));
        eg_ins_mask_i = 4'hF;
        ctrl0_i[0] = 8'h02;
        stall = 0;
        send(1, b);
        chk("rem_len", b + 16, sink.cnt);
        chk("rem_fcs", crc(b, 12), at(b + 12));
        send(0, b);
        chk("untag_len", b + 20, sink.cnt);
        chk("untag_data", 32'h0F0E0D0C, at(b + 12));
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clock_i);
        #1 rst_i = 0;
        t_port();
        t_tag();
        t_stp();
        t_egress();
        print_verdict();
    end
endmodule
